/* File: xbt_pkg.sv */
/*
  Shared constants and carrier types for the board test chain block.
  Assumes a single 100 MHz clock domain; pins are sampled synchronously.

  What the chain mode does, rule by rule:
*/
// What this block does
// - Sampling the strap pair and the lane-0 pin both low at the release of the host bus reset enters test mode.
// - Sampling either of those pins high at a later release of the host bus reset leaves test mode.
// - A power-on reset clears test mode whatever the pin levels.
// - While test mode is active every pad function is cut off and every pad is an input except the chain output.
// - The chain result leaves on the shared tachometer pin, driven only while test mode is active.
// - The host bus reset pin and the supply pins do not feed the chain; every other signal pin does.
// - In test mode a change of any single chain input inverts the chain output, which is the parity of all inputs.
// - After entry the strap pair pins act as ordinary chain inputs.
// - With all inputs low, or all high, the chain output is low, the input count being even.
// - After exit, toggling any former chain input no longer changes the chain output pin.
package xbt_pkg;

  // Number of signal pins feeding the chain (must be even)
  localparam int unsigned XBT_CHAIN_W    = 94;
  // Index of the frame strap and lane-0 pins within the chain vector
  localparam int unsigned XBT_FRAME_IDX  = 0;
  localparam int unsigned XBT_LAD0_IDX   = 1;
  // Reset value of the mode flag
  localparam logic        XBT_MODE_RST   = 1'b0;
  // Reset value of the chain output register
  localparam logic        XBT_OUT_RST    = 1'b0;
  // Reset value of the host bus reset history; high so that a power-on
  // reset with the host pin already high never looks like a release
  localparam logic        XBT_HBR_RST    = 1'b1;

  // Mode tracking states
  typedef enum logic [0:0] {
    XBT_NORMAL = 1'b0,
    XBT_CHAIN  = 1'b1
  } xbt_mode_e;

  // Pad drive for the shared tachometer pin
  typedef struct packed {
    logic o;
    logic oe;
  } xbt_pad_s;

endpackage

/* File: xbt_chain.sv */
/*
  Board test chain mode: strap capture on host bus reset release,
  pad cut-off strobe, and the parity chain onto the tachometer pin.
  Assumes pins arrive synchronous to clk; resetn is the power-on reset.

  Behaviour in brief:
    The mode flag moves only on a rising edge of the host bus reset pin,
    seen as a low-to-high step between two clock edges, or on resetn.
    While the flag is set the tachometer pad is driven with the parity
    of every chain input, one clock behind the pins.
    While the flag is clear the pad is released and its value held low.
  Hazards:
    The edge history resets high, so a power-on reset with the host pin
    already high cannot fake a release and re-enter the mode.
    The chain width must stay even, or all-high inputs give a high pad.
*/
`timescale 1ns/1ns
module xbt_chain
  import xbt_pkg::*;
#(
  parameter int unsigned CHAIN_W = XBT_CHAIN_W
) (
  // Clock and power-on reset
  input  wire logic               clk,
  input  wire logic               resetn,
  // Host bus reset pin, excluded from the chain
  input  wire logic               host_bus_reset_n,
  // All other signal pin inputs, frame strap and lane 0 included
  input  wire logic [CHAIN_W-1:0] chain_in,
  // Shared tachometer pin drive
  output logic                    chain_output_pin_o,
  output logic                    chain_output_pin_oe,
  // High while pad functions are cut off
  output logic                    test_mode
);

  xbt_mode_e mode_r;
  xbt_mode_e mode_nxt;
  logic      hbr_q_r;
  xbt_pad_s  pad_r;
  xbt_pad_s  pad_nxt;

  // Release edge and strap decode
  wire logic release_edge = host_bus_reset_n & ~hbr_q_r;
  wire logic straps_low   = ~chain_in[XBT_FRAME_IDX] &
                            ~chain_in[XBT_LAD0_IDX];
  // Parity of all chain inputs; even count keeps all-high low
  wire logic parity       = ^chain_in;

  // Mode next value, loaded only at release
  always_comb begin
    mode_nxt = mode_r;
    if (release_edge) begin
      mode_nxt = straps_low ? XBT_CHAIN : XBT_NORMAL;
    end
  end

  // Pad next value
  always_comb begin
    pad_nxt.oe = (mode_nxt == XBT_CHAIN);
    pad_nxt.o  = (mode_nxt == XBT_CHAIN) ? parity : XBT_OUT_RST;
  end

  // Mode flag, power-on cleared
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_r  <= XBT_NORMAL;
      hbr_q_r <= XBT_HBR_RST;
      pad_r   <= '{o: XBT_OUT_RST, oe: 1'b0};
    end else begin
      mode_r  <= mode_nxt;
      hbr_q_r <= host_bus_reset_n;
      pad_r   <= pad_nxt;
    end
  end

  assign chain_output_pin_o  = pad_r.o;
  assign chain_output_pin_oe = pad_r.oe;
  assign test_mode           = pad_r.oe;

  // Checks
  property p_enter;
    @(posedge clk) disable iff (!resetn)
      (host_bus_reset_n && !$past(host_bus_reset_n) && straps_low)
      |=> test_mode;
  endproperty
  a_enter: assert property (p_enter) else $error("entry missed");

  property p_exit;
    @(posedge clk) disable iff (!resetn)
      (host_bus_reset_n && !$past(host_bus_reset_n) && !straps_low)
      |=> !test_mode;
  endproperty
  a_exit: assert property (p_exit) else $error("exit missed");

  property p_por;
    @(posedge clk) !resetn |=> !test_mode && !chain_output_pin_oe;
  endproperty
  a_por: assert property (p_por) else $error("por not cleared");

  property p_stable;
    @(posedge clk) disable iff (!resetn)
      !(host_bus_reset_n && !$past(host_bus_reset_n))
      |=> $stable(test_mode);
  endproperty
  a_stable: assert property (p_stable) else $error("mode moved");

  property p_parity;
    @(posedge clk) disable iff (!resetn)
      (mode_nxt == XBT_CHAIN) |=> chain_output_pin_o == $past(^chain_in);
  endproperty
  a_parity: assert property (p_parity) else $error("bad parity");

  property p_toggle;
    @(posedge clk) disable iff (!resetn)
      (test_mode && mode_nxt == XBT_CHAIN && $countones(chain_in ^
        $past(chain_in)) == 1) |=> $changed(chain_output_pin_o);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle");

  property p_oe;
    @(posedge clk) disable iff (!resetn)
      chain_output_pin_oe == test_mode;
  endproperty
  a_oe: assert property (p_oe) else $error("oe mismatch");

  property p_quiet;
    @(posedge clk) disable iff (!resetn)
      !test_mode |-> !chain_output_pin_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("output live");

  property p_even;
    @(posedge clk) disable iff (!resetn)
      (mode_nxt == XBT_CHAIN && (&chain_in || ~|chain_in))
      |=> !chain_output_pin_o;
  endproperty
  a_even: assert property (p_even) else $error("even not low");

  // Mode flag checks

  // Host pin held low alone never moves the mode
  property p_hold_low;
    @(posedge clk) disable iff (!resetn)
      !host_bus_reset_n |=> $stable(test_mode);
  endproperty
  a_hold_low: assert property (p_hold_low) else $error("low moved");

  // Mode flag and pad enable come from the same decision
  property p_mode_match;
    @(posedge clk) disable iff (!resetn)
      test_mode == (mode_r == XBT_CHAIN);
  endproperty
  a_mode_match: assert property (p_mode_match) else $error("flag split");

  // Enable rises only after a release edge
  property p_oe_rise;
    @(posedge clk) disable iff (!resetn)
      $rose(chain_output_pin_oe) |-> $past(release_edge);
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("stray rise");

  // Enable falls only after a release edge or a power-on reset
  property p_oe_fall;
    @(posedge clk) disable iff (!resetn)
      $fell(chain_output_pin_oe) |-> $past(release_edge) || !$past(resetn);
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("stray fall");

  // Mode held between release edges
  property p_mode_stays;
    @(posedge clk) disable iff (!resetn)
      test_mode && !release_edge |=> test_mode;
  endproperty
  a_mode_stays: assert property (p_mode_stays) else $error("mode lost");

  // Normal operation held between release edges
  property p_exit_stays;
    @(posedge clk) disable iff (!resetn)
      !test_mode && !release_edge |=> !test_mode;
  endproperty
  a_exit_stays: assert property (p_exit_stays) else $error("mode crept");

  // A release is always a low-to-high step of the host pin
  property p_release_low;
    @(posedge clk) disable iff (!resetn)
      release_edge |-> !$past(host_bus_reset_n);
  endproperty
  a_release_low: assert property (p_release_low) else $error("false edge");

  // No release edge straight after power-on reset
  property p_no_false_edge;
    @(posedge clk) disable iff (!resetn)
      $rose(resetn) |-> !release_edge;
  endproperty
  a_no_false_edge: assert property (p_no_false_edge)
    else $error("edge after por");

  // Power-on reset drops the pad value too
  property p_por_out;
    @(posedge clk) !resetn |=> !chain_output_pin_o;
  endproperty
  a_por_out: assert property (p_por_out) else $error("por out high");

  // Pad checks

  // Released pad carries no value
  property p_off_low;
    @(posedge clk) disable iff (!resetn)
      !chain_output_pin_oe |-> !chain_output_pin_o;
  endproperty
  a_off_low: assert property (p_off_low) else $error("off pad high");

  // Entry turns the pad driver on
  property p_enter_oe;
    @(posedge clk) disable iff (!resetn)
      release_edge && straps_low |=> chain_output_pin_oe;
  endproperty
  a_enter_oe: assert property (p_enter_oe) else $error("pad not on");

  // Entry shows the parity at once
  property p_enter_out;
    @(posedge clk) disable iff (!resetn)
      release_edge && straps_low |=> chain_output_pin_o == $past(parity);
  endproperty
  a_enter_out: assert property (p_enter_out) else $error("entry value");

  // Exit releases the pad and drops its value
  property p_exit_oe;
    @(posedge clk) disable iff (!resetn)
      release_edge && !straps_low |=> !chain_output_pin_oe &&
        !chain_output_pin_o;
  endproperty
  a_exit_oe: assert property (p_exit_oe) else $error("pad still on");

  // Chain checks

  // Frame strap alone toggles the output once in the mode
  property p_frame_in;
    @(posedge clk) disable iff (!resetn)
      (test_mode && mode_nxt == XBT_CHAIN &&
        $countones(chain_in ^ $past(chain_in)) == 1 &&
        $changed(chain_in[XBT_FRAME_IDX])) |=> $changed(chain_output_pin_o);
  endproperty
  a_frame_in: assert property (p_frame_in) else $error("frame dead");

  // Lane-0 pin alone toggles the output once in the mode
  property p_lane_in;
    @(posedge clk) disable iff (!resetn)
      (test_mode && mode_nxt == XBT_CHAIN &&
        $countones(chain_in ^ $past(chain_in)) == 1 &&
        $changed(chain_in[XBT_LAD0_IDX])) |=> $changed(chain_output_pin_o);
  endproperty
  a_lane_in: assert property (p_lane_in) else $error("lane dead");

  // The last pin of the vector feeds the chain as well
  property p_top_in;
    @(posedge clk) disable iff (!resetn)
      (test_mode && mode_nxt == XBT_CHAIN &&
        $countones(chain_in ^ $past(chain_in)) == 1 &&
        $changed(chain_in[CHAIN_W-1])) |=> $changed(chain_output_pin_o);
  endproperty
  a_top_in: assert property (p_top_in) else $error("top pin dead");

  // Two pins changing together cancel
  property p_two_change;
    @(posedge clk) disable iff (!resetn)
      (test_mode && mode_nxt == XBT_CHAIN &&
        $countones(chain_in ^ $past(chain_in)) == 2)
      |=> $stable(chain_output_pin_o);
  endproperty
  a_two_change: assert property (p_two_change) else $error("pair moved");

  // Quiet pins give a quiet output
  property p_steady;
    @(posedge clk) disable iff (!resetn)
      (test_mode && mode_nxt == XBT_CHAIN && $stable(chain_in))
      |=> $stable(chain_output_pin_o);
  endproperty
  a_steady: assert property (p_steady) else $error("output moved");

  // All inputs low gives a low output
  property p_all_low;
    @(posedge clk) disable iff (!resetn)
      (mode_nxt == XBT_CHAIN && ~|chain_in) |=> !chain_output_pin_o;
  endproperty
  a_all_low: assert property (p_all_low) else $error("low not low");

  // All inputs high gives a low output
  property p_all_high;
    @(posedge clk) disable iff (!resetn)
      (mode_nxt == XBT_CHAIN && &chain_in) |=> !chain_output_pin_o;
  endproperty
  a_all_high: assert property (p_all_high) else $error("high not low");

  c_enter: cover property (@(posedge clk) disable iff (!resetn)
    !test_mode ##1 test_mode);
  c_exit: cover property (@(posedge clk) disable iff (!resetn)
    test_mode ##1 !test_mode);
  c_tog: cover property (@(posedge clk) disable iff (!resetn)
    test_mode && $changed(chain_output_pin_o));
  // Every input high while the mode holds
  c_all_high: cover property (@(posedge clk) disable iff (!resetn)
    test_mode && &chain_in);
  // Host pin low while the mode holds
  c_hold: cover property (@(posedge clk) disable iff (!resetn)
    test_mode && !host_bus_reset_n);

endmodule // xbt_chain

/* File: xbt_board.sv */
/* Board side of the chain output pin as the tester's probe sees it.
   Assumes the pad drive comes straight from the chain block. */
`timescale 1ns/1ns
module xbt_board
  import xbt_pkg::*;
(
  // Clock
  input  wire logic     clk,
  // Pad drive from the device
  input  wire xbt_pad_s pad,
  // Level on the probe
  output logic          pin
);
  logic last_r;
  // Floating pin must not look like a held level
  always_ff @(posedge clk) last_r <= pin;
  assign pin = pad.oe ? pad.o : ~last_r;
endmodule // xbt_board

/* File: tb.sv */
/* Self-checking bench for the board test chain block.
   Assumes a narrow chain; the bench acts as the board tester. */
`timescale 1ns/1ns
module tb;
  import xbt_pkg::*;
  localparam int CW = 8;
  typedef struct packed { logic [CW-1:0] cin; logic o; } xbt_row_s;
  logic          clk, resetn, hbr_n, pin, tm;
  logic [CW-1:0] cin, v;
  wire xbt_pad_s pad;
  int            bad_count, samples_checked, cyc;
  xbt_row_s      rows [6] = '{'{8'h00, 1'b0}, '{8'hFF, 1'b0},
    '{8'h01, 1'b1}, '{8'h02, 1'b1}, '{8'h3C, 1'b0}, '{8'h7F, 1'b1}};
  xbt_chain #(.CHAIN_W(CW)) i_dut (.clk(clk), .resetn(resetn),
    .host_bus_reset_n(hbr_n), .chain_in(cin), .chain_output_pin_o(pad.o),
    .chain_output_pin_oe(pad.oe), .test_mode(tm));
  xbt_board i_board (.clk(clk), .pad(pad), .pin(pin));
  // Compare and count
  task automatic chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %0t got %b want %b", $time, got, exp);
      bad_count++;
    end
  endtask
  // Drive pins, wait for the registered output
  task automatic put(input logic [CW-1:0] d);
    @(posedge clk) cin <= d;
    @(posedge clk) #1;
  endtask
  // Pulse host bus reset with given strap levels
  task automatic rel(input logic [CW-1:0] d);
    @(posedge clk) begin
      hbr_n <= 1'b0;
      cin <= d;
    end
    @(posedge clk) hbr_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Report and end
  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      close_out();
    end
  end
  // Main sequence
  initial begin
    resetn = 1'b0;
    hbr_n = 1'b0;
    cin = '0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk) #1;
    chk(pad.oe, 1'b0);
    rel('0);
    chk(tm, 1'b1);
    chk(pad.oe, 1'b1);
    foreach (rows[i]) begin
      put(rows[i].cin);
      chk(pin, rows[i].o);
    end
    v = '0;
    put(v);
    for (int i = CW - 1; i >= 0; i--) begin
      v[i] = 1'b1;
      put(v);
      chk(pin, 1'((CW - i) % 2));
    end
    for (int i = 0; i < CW; i++) begin
      v[i] = 1'b0;
      put(v);
      chk(pin, 1'((CW - 1 - i) % 2));
    end
    @(posedge clk) hbr_n <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk(tm, 1'b1);
    chk(pin, 1'b0);
    rel(8'h01);
    chk(tm, 1'b0);
    put(8'hFE);
    chk(pad.o, 1'b0);
    rel('0);
    rel(8'h02);
    chk(pad.oe, 1'b0);
    rel('0);
    @(posedge clk) resetn <= 1'b0;
    @(posedge clk) resetn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(tm, 1'b0);
    close_out();
  end
endmodule // tb
